// >>> fpc_unit.sv
// Purpose: FP operand classifier, multiplier and integer mul/div
// Assumes: Classic Wishbone slave, one clock, 32-bit data
// Notes: Results and flags publish after the variant latency
//
// Contract
// RULE1: Double exponent is an 11-bit unsigned field, bias 1023.
// RULE2: Only exponent fields 1..2046 are ordinary normal numbers.
// RULE3: Separate sign bit, 0 positive, 1 negative; magnitude unsigned.
// RULE4: Normal significands get an implicit leading one restored.
// RULE5: Normal value is 1.f times two to e minus 1023.
// RULE6: Exponent zero: zero fraction is signed zero, else denormal.
// RULE7: Exponent 2047: zero fraction is infinity, else NaN.
// RULE8: Top fraction bit clear means quiet NaN, set signalling.
// RULE9: Four rounding modes: up, down, toward zero, nearest.
// RULE10: Result is exact product rounded once in selected mode.
// RULE11: Nearest mode resolves an exact tie toward zero.
// RULE12: Five exception flags, each selectable to trap or not.
// RULE13: Untrapped overflow and divide by zero give infinity; the integer divide by zero here returns zero quotient and remainder.
// RULE14: Quiet NaN operand raises nothing, result is NaN.
// RULE15: Signalling NaN operand raises invalid on every use; here only the multiply raises it, the classify command raises nothing.
// RULE16: Baseline traps any denormal operand or result.
// RULE17: Enhanced option flushes denormal results to zero.
// RULE18: Multiply takes 8 cycles, or 4 single / 5 double fast.
// RULE19: Integer multiply and divide run in this unit.
// RULE20: Reduced variant traps every double precision operation; here only the double multiply traps, a double classify does not.
// RULE21: Single operands use 32 bits, doubles 64 bits.
// RULE22: Baseline traps any exceptional case but inexact, overflow; here only for the multiply, integer divide by zero and classify do not trap.
// RULE23: One-hot operand class decoded combinationally.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
module fpc_unit (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Async reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic fp_trap // Trap to pipeline
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] bmrg(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
                r[8*i +: 8] = d[8*i +: 8];
        end
        return r;
    endfunction

    // Single word widened to double layout, class preserved
    function automatic logic [63:0] wid(input logic [31:0] w);
        logic [10:0] e;
        e = {3'h0, w[30:23]} + fpc_pkg::SREB;
        if (w[30:23] == 8'h00)
            e = 11'h000;
        if (w[30:23] == 8'hFF)
            e = fpc_pkg::EMAX;
        return {w[31], e, w[22:0], 29'h0};
    endfunction

    function automatic logic [5:0] cls(input logic [62:0] m);
        logic [5:0] c;
        c = 6'h00;
        if (m[62:52] == 11'h000)
            c[m[51:0] == 52'h0 ? fpc_pkg::CZERO : fpc_pkg::CDEN] = 1'b1;
        else if (m[62:52] != fpc_pkg::EMAX)
            c[fpc_pkg::CNRM] = 1'b1;
        else if (m[51:0] == 52'h0)
            c[fpc_pkg::CINF] = 1'b1;
        else
            c[m[51] ? fpc_pkg::CSNAN : fpc_pkg::CQNAN] = 1'b1;
        return c;
    endfunction

    // Pack sign, exponent, fraction in the result precision
    function automatic logic [63:0] mk(input logic g, input logic s,
        input logic [10:0] e, input logic [51:0] f);
        return g ? {32'h0, s, e[7:0], f[51:29]} : {s, e, f};
    endfunction

    ////////////////////////////////////////////////////////////////
    logic [11:0] ctrl;
    logic [63:0] opa;
    logic [63:0] opb;
    logic [63:0] res;
    logic [4:0] cause;
    logic [4:0] acc;
    logic unimp;
    fpc_pkg::fpc_st_t st;
    fpc_pkg::fpc_st_t next_st;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [63:0] pres;
    logic [4:0] pfl;
    logic pun;
    logic ptr;

    logic req;
    logic wr;
    logic start;
    logic sfm;
    logic pub;
    logic busy;
    logic [1:0] cop;
    logic [31:0] ctrl_m;
    logic [31:0] rdat;
    logic [4:0] clr;
    logic [1:0] rm;
    logic sgl;
    logic fast;
    logic enh;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign cop = wb_dat_i[1:0];
    assign busy = (st == fpc_pkg::ST_RUN);
    assign start = wr & (wb_adr_i == fpc_pkg::A_CMD) & wb_sel_i[0]
        & ~busy;
    assign sfm = start & (cop == fpc_pkg::OFMUL);
    assign pub = busy & (cnt == 4'h0);
    assign ctrl_m = bmrg({20'h0, ctrl}, wb_dat_i, wb_sel_i);
    assign rm = ctrl[fpc_pkg::C_RM +: 2];
    assign sgl = ctrl[fpc_pkg::C_SGL];
    assign fast = ctrl[fpc_pkg::C_FAST];
    assign enh = ctrl[fpc_pkg::C_ENH];
    assign clr = (wr & (wb_adr_i == fpc_pkg::A_FLAG) & wb_sel_i[0])
        ? wb_dat_i[4:0] : 5'h00;

    ////////////////////////////////////////////////////////////////
    // Operand decode
    logic [63:0] a;
    logic [63:0] b;
    logic [5:0] ca;
    logic [5:0] cb;
    logic [5:0] an;
    logic sgn;

    assign a = sgl ? wid(opa[31:0]) : opa; // RULE21
    assign b = sgl ? wid(opb[31:0]) : opb; // RULE21
    assign ca = cls(a[62:0]); // RULE23 RULE2 RULE6 RULE7 RULE8
    assign cb = cls(b[62:0]); // RULE23
    assign an = ca | cb;
    assign sgn = a[63] ^ b[63]; // RULE3

    ////////////////////////////////////////////////////////////////
    // Exact product, one rounding step
    logic [105:0] prod;
    logic [105:0] nrm;
    logic top;
    logic [13:0] ex;
    logic [52:0] kp;
    logic [53:0] kr;
    logic gd;
    logic sk;
    logic inx;
    logic inc;
    logic cy;
    logic [13:0] exr;
    logic ovf;
    logic unf;
    logic [51:0] fr;

    assign prod = {1'b1, a[51:0]} * {1'b1, b[51:0]}; // RULE4
    assign top = prod[105];
    assign nrm = top ? prod : {prod[104:0], 1'b0};
    assign ex = {3'h0, a[62:52]} + {3'h0, b[62:52]} - fpc_pkg::BIAS
        + {13'h0, top}; // RULE1 RULE5
    assign kp = sgl ? {29'h0, nrm[105:82]} : nrm[105:53];
    assign gd = sgl ? nrm[81] : nrm[52];
    assign sk = sgl ? |nrm[80:0] : |nrm[51:0];
    assign inx = gd | sk;
    assign inc = (rm == fpc_pkg::RNEAR) ? (gd & sk) // RULE11
        : (rm == fpc_pkg::RUP) ? (inx & ~sgn) // RULE9
        : (rm == fpc_pkg::RDOWN) ? (inx & sgn) : 1'b0; // RULE9
    assign kr = {1'b0, kp} + {53'h0, inc}; // RULE10
    assign cy = sgl ? kr[24] : kr[53];
    assign exr = ex + {13'h0, cy} - (sgl ? fpc_pkg::SREB14 : 14'h0);
    assign ovf = ~exr[13] & (exr > (sgl ? fpc_pkg::SEMX : fpc_pkg::DEMX));
    assign unf = exr[13] | (exr == 14'h0);
    assign fr = sgl ? {kr[22:0], 29'h0} : kr[51:0];

    ////////////////////////////////////////////////////////////////
    // Special operands and default results
    logic [63:0] f_res;
    logic [4:0] f_fl;
    logic f_hold;
    logic f_un;

    always_comb
    begin
        f_res = mk(sgl, sgn, exr[10:0], fr);
        f_fl = 5'h00;
        f_hold = 1'b0;
        if (an[fpc_pkg::CSNAN] | (an[fpc_pkg::CZERO] & an[fpc_pkg::CINF]))
        begin
            f_res = mk(sgl, 1'b0, fpc_pkg::EMAX, fpc_pkg::QNF);
            f_fl[fpc_pkg::FINV] = 1'b1; // RULE15
        end
        else if (an[fpc_pkg::CQNAN])
            f_res = mk(sgl, 1'b0, fpc_pkg::EMAX, fpc_pkg::QNF); // RULE14
        else if (an[fpc_pkg::CINF])
            f_res = mk(sgl, sgn, fpc_pkg::EMAX, 52'h0);
        else if (an[fpc_pkg::CZERO])
            f_res = mk(sgl, sgn, 11'h000, 52'h0);
        else if (an[fpc_pkg::CDEN])
            f_hold = 1'b1; // RULE16
        else if (ovf)
        begin
            f_res = mk(sgl, sgn, fpc_pkg::EMAX, 52'h0); // RULE13
            f_fl[fpc_pkg::FOVF] = 1'b1;
            f_fl[fpc_pkg::FINX] = 1'b1;
        end
        else if (unf)
        begin
            f_fl[fpc_pkg::FUNF] = 1'b1;
            f_fl[fpc_pkg::FINX] = 1'b1;
            if (enh & ctrl[fpc_pkg::C_FTZ])
                f_res = mk(sgl, sgn, 11'h000, 52'h0); // RULE17
            else
                f_hold = 1'b1; // RULE16
        end
        else
            f_fl[fpc_pkg::FINX] = inx;
    end

    assign f_un = f_hold | (~enh & ((|(an & ~fpc_pkg::CLOK))
        | f_fl[fpc_pkg::FINV] | f_fl[fpc_pkg::FUNF])) // RULE22
        | (ctrl[fpc_pkg::C_SONLY] & ~sgl); // RULE20

    ////////////////////////////////////////////////////////////////
    // Integer operations and command select
    logic [63:0] imul;
    logic dz;
    logic [31:0] iq;
    logic [31:0] ir;
    logic [63:0] n_res;
    logic [4:0] n_fl;
    logic n_un;
    logic [3:0] lat;

    assign imul = {32'h0, opa[31:0]} * {32'h0, opb[31:0]}; // RULE19
    assign dz = (opb[31:0] == 32'h0);
    assign iq = dz ? 32'h0 : opa[31:0] / opb[31:0]; // RULE19
    assign ir = dz ? 32'h0 : opa[31:0] % opb[31:0];
    assign lat = (cop == fpc_pkg::OFCLS) ? fpc_pkg::LCLS
        : ~fast ? fpc_pkg::LBAS // RULE18
        : sgl ? fpc_pkg::LFS : fpc_pkg::LFD; // RULE18

    always_comb
    begin
        n_res = a;
        n_fl = 5'h00;
        n_un = 1'b0;
        case (cop)
            fpc_pkg::OFMUL:
            begin
                n_res = f_res;
                n_fl = f_fl;
                n_un = f_un;
            end
            fpc_pkg::OIMUL:
                n_res = imul;
            fpc_pkg::OIDIV:
            begin
                n_res = {ir, iq};
                n_fl[fpc_pkg::FDIVZ] = dz; // RULE12
            end
            default:
                n_res = a;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        case (st)
            fpc_pkg::ST_IDLE:
                if (start)
                begin
                    next_st = fpc_pkg::ST_RUN;
                    next_cnt = lat - 4'h1;
                end
            fpc_pkg::ST_RUN:
                if (cnt == 4'h0)
                    next_st = fpc_pkg::ST_IDLE;
                else
                    next_cnt = cnt - 4'h1;
            default:
                next_st = fpc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= fpc_pkg::ST_IDLE;
            cnt <= 4'h0;
            pres <= 64'h0;
            pfl <= 5'h00;
            pun <= 1'b0;
            ptr <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            if (start)
            begin
                pres <= n_res;
                pfl <= n_fl;
                pun <= n_un;
                ptr <= n_un | (|(n_fl & ctrl[fpc_pkg::C_TEN +: 5])); // RULE12
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res <= 64'h0;
            cause <= 5'h00;
            acc <= 5'h00;
            unimp <= 1'b0;
            fp_trap <= 1'b0;
        end
        else
        begin
            acc <= (acc & ~clr) | (pub ? pfl : 5'h00); // RULE12
            if (pub)
            begin
                res <= pres;
                cause <= pfl;
                unimp <= pun;
                fp_trap <= ptr;
            end
            else if (start)
                fp_trap <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register bus
    always_comb
    begin
        case (wb_adr_i)
            fpc_pkg::A_CTRL: rdat = {20'h0, ctrl};
            fpc_pkg::A_OPAL: rdat = opa[31:0];
            fpc_pkg::A_OPAH: rdat = opa[63:32];
            fpc_pkg::A_OPBL: rdat = opb[31:0];
            fpc_pkg::A_OPBH: rdat = opb[63:32];
            fpc_pkg::A_STAT: rdat = {7'h0, cause, 1'b0, unimp, fp_trap,
                busy, 2'h0, cb, 2'h0, ca};
            fpc_pkg::A_RESL: rdat = res[31:0];
            fpc_pkg::A_RESH: rdat = res[63:32];
            fpc_pkg::A_FLAG: rdat = {27'h0, acc};
            default: rdat = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl <= fpc_pkg::CTRL_RST;
            opa <= 64'h0;
            opb <= 64'h0;
        end
        else
        begin
            wb_ack_o <= req;
            if (req)
                wb_dat_o <= rdat;
            if (wr & (wb_adr_i == fpc_pkg::A_CTRL))
                ctrl <= ctrl_m[11:0];
            if (wr & (wb_adr_i == fpc_pkg::A_OPAL))
                opa[31:0] <= bmrg(opa[31:0], wb_dat_i, wb_sel_i);
            if (wr & (wb_adr_i == fpc_pkg::A_OPAH))
                opa[63:32] <= bmrg(opa[63:32], wb_dat_i, wb_sel_i);
            if (wr & (wb_adr_i == fpc_pkg::A_OPBL))
                opb[31:0] <= bmrg(opb[31:0], wb_dat_i, wb_sel_i);
            if (wr & (wb_adr_i == fpc_pkg::A_OPBH))
                opb[63:32] <= bmrg(opb[63:32], wb_dat_i, wb_sel_i);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_lat_basic: assert property ( // RULE18
        sfm && !fast |=> busy [*8] ##1 !busy)
        else $error("basic multiply latency not 8");
    a_lat_fast_dbl: assert property ( // RULE18
        sfm && fast && !sgl |=> busy [*5] ##1 !busy)
        else $error("fast double multiply latency not 5");
    a_lat_fast_sgl: assert property ( // RULE18
        sfm && fast && sgl |=> busy [*4] ##1 !busy)
        else $error("fast single multiply latency not 4");
    a_class_onehot: assert property ($onehot(ca) && $onehot(cb)) // RULE23
        else $error("operand class not one-hot");
    a_norm_range: assert property (ca[fpc_pkg::CNRM] == // RULE2
        (a[62:52] >= 11'h001 && a[62:52] <= 11'h7FE))
        else $error("normal class outside exponent range");
    a_nan_kind: assert property ( // RULE8
        ca[fpc_pkg::CQNAN] || ca[fpc_pkg::CSNAN]
        |-> ca[fpc_pkg::CSNAN] == a[51])
        else $error("NaN kind not from top fraction bit");
    a_snan_invalid: assert property ( // RULE15
        sfm && an[fpc_pkg::CSNAN] |=> pfl[fpc_pkg::FINV])
        else $error("signalling NaN did not raise invalid");
    a_qnan_quiet: assert property ( // RULE14
        sfm && an[fpc_pkg::CQNAN] && !an[fpc_pkg::CSNAN]
        |=> !pfl[fpc_pkg::FINV] && (pres[62:52] == 11'h7FF
        || pres[30:23] == 8'hFF))
        else $error("quiet NaN operand misbehaved");
    a_trap_publish: assert property ( // RULE12
        pub && ptr |=> fp_trap && !busy && $stable(pres))
        else $error("trap not raised at publish");

    c_fast_mul: cover property (sfm && fast);
    c_trap: cover property ($rose(fp_trap));
    c_tie: cover property (sfm && rm == fpc_pkg::RNEAR && gd && !sk);
    c_div_zero: cover property (start && cop == fpc_pkg::OIDIV && dz);
endmodule

// >>> fpc_pkg.sv
// Purpose: Shared constants of the FP classifier unit
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Status word: [5:0] class A, [13:8] class B, 16 busy,
// Notes: 17 trap, 18 unimplemented, [24:20] last cause flags
package fpc_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OPAL = 8'h04;
    localparam logic [7:0] A_OPAH = 8'h08;
    localparam logic [7:0] A_OPBL = 8'h0C;
    localparam logic [7:0] A_OPBH = 8'h10;
    localparam logic [7:0] A_CMD = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_RESL = 8'h1C;
    localparam logic [7:0] A_RESH = 8'h20;
    localparam logic [7:0] A_FLAG = 8'h24;
    // Control fields
    localparam int C_RM = 0;
    localparam int C_FTZ = 2;
    localparam int C_TEN = 3;
    localparam int C_FAST = 8;
    localparam int C_SONLY = 9;
    localparam int C_ENH = 10;
    localparam int C_SGL = 11;
    localparam logic [11:0] CTRL_RST = 12'h000;
    // Rounding modes
    localparam logic [1:0] RNEAR = 2'h0;
    localparam logic [1:0] RZERO = 2'h1;
    localparam logic [1:0] RUP = 2'h2;
    localparam logic [1:0] RDOWN = 2'h3;
    // Commands
    localparam logic [1:0] OFMUL = 2'h0;
    localparam logic [1:0] OIMUL = 2'h1;
    localparam logic [1:0] OIDIV = 2'h2;
    localparam logic [1:0] OFCLS = 2'h3;
    // Exception flag positions
    localparam int FINV = 0;
    localparam int FDIVZ = 1;
    localparam int FOVF = 2;
    localparam int FUNF = 3;
    localparam int FINX = 4;
    // Class positions
    localparam int CZERO = 0;
    localparam int CDEN = 1;
    localparam int CNRM = 2;
    localparam int CINF = 3;
    localparam int CQNAN = 4;
    localparam int CSNAN = 5;
    localparam logic [5:0] CLOK = 6'h05;
    // Format constants
    localparam logic [10:0] EMAX = 11'h7FF;
    localparam logic [10:0] SREB = 11'h380;
    localparam logic [13:0] BIAS = 14'h03FF;
    localparam logic [13:0] SREB14 = 14'h0380;
    localparam logic [13:0] DEMX = 14'h07FE;
    localparam logic [13:0] SEMX = 14'h00FE;
    localparam logic [51:0] QNF = 52'h7FFFFFFFFFFFF;
    // Latencies in cycles
    localparam logic [3:0] LBAS = 4'h8;
    localparam logic [3:0] LFS = 4'h4;
    localparam logic [3:0] LFD = 4'h5;
    localparam logic [3:0] LCLS = 4'h1;
    typedef enum logic {ST_IDLE, ST_RUN} fpc_st_t;
endpackage

// >>> fpc_pipe_model.sv
// Purpose: Pipeline side model that takes traps from the FP unit
// Assumes: Trap is a registered level in the single core clock
// Notes: Records the bench cycle count at every trap rise
`timescale 1ns/1ps
module fpc_pipe_model (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic fp_trap, // Trap level from unit
    input wire logic [31:0] cyc_now, // Free running cycle count
    output logic [31:0] trap_count, // Trap rises taken
    output logic [31:0] rise_cycle // Cycle of last rise
);
    logic trap_q;
    wire trap_rise;
    ////////////////////////////////////////////////////////////////////
    assign trap_rise = fp_trap && !trap_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trap_q <= 1'b0;
            trap_count <= 32'h0;
            rise_cycle <= 32'h0;
        end
        else
        begin
            trap_q <= fp_trap;
            if (trap_rise)
            begin
                trap_count <= trap_count + 32'h1;
                rise_cycle <= cyc_now;
            end
        end
    end
endmodule

// >>> fp_double_format_classifier_tb_top.sv
// Purpose: Self-checking bench for the FP classifier unit
// Assumes: Classic Wishbone master, one clock at 50 MHz
// Notes: Trap latency is timed by the pipeline model
`timescale 1ns/1ps
module fp_double_format_classifier_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic fp_trap;
    logic [31:0] cyc_now = 32'h0;
    logic [31:0] trap_count;
    logic [31:0] rise_cycle;
    logic [31:0] ack_cyc;
    logic [31:0] q;
    int bad_count = 0;
    int checked = 0;
    logic [11:0] cc [11] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
        12'h000, 12'h000, 12'h000, 12'h800, 12'h800, 12'h800};
    logic [31:0] ch [11] = '{32'h0, 32'h80000000, 32'h0, 32'h00100000,
        32'h7FE00000, 32'hFFF00000, 32'h7FF00000, 32'h7FF80000, 32'h0,
        32'h0, 32'h0};
    logic [31:0] cl [11] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'hFFFFFFFF,
        32'h0, 32'h1, 32'h0, 32'h7F800000, 32'h1, 32'h7FC00000};
    logic [5:0] ck [11] = '{6'h01, 6'h01, 6'h02, 6'h04, 6'h04, 6'h08,
        6'h10, 6'h20, 6'h08, 6'h02, 6'h20};
    ////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    always @(posedge clk) cyc_now <= cyc_now + 32'h1;
    fpc_unit dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .fp_trap(fp_trap));
    fpc_pipe_model pipe (.clk(clk), .rst_n(rst_n), .fp_trap(fp_trap),
        .cyc_now(cyc_now), .trap_count(trap_count),
        .rise_cycle(rise_cycle));
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [63:0] e,
        input logic [63:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            cmp("ack", 64'h1, 64'h0);
        r = wb_dat_o;
        ack_cyc = cyc_now;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, 4'hF, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 4'hF, 32'h0, r);
    endtask
    task automatic ld(input logic [63:0] a, input logic [63:0] b);
        wr(fpc_pkg::A_OPAL, a[31:0]);
        wr(fpc_pkg::A_OPAH, a[63:32]);
        wr(fpc_pkg::A_OPBL, b[31:0]);
        wr(fpc_pkg::A_OPBH, b[63:32]);
    endtask
    task automatic run(input logic [1:0] op, output logic [31:0] st,
        output logic [31:0] tk);
        int n;
        n = 0;
        wr(fpc_pkg::A_CMD, {30'h0, op});
        tk = ack_cyc;
        do
        begin
            rd(fpc_pkg::A_STAT, st);
            n++;
        end
        while (st[16] !== 1'b0 && n < 20);
        if (n >= 20)
            cmp("busy", 64'h0, 64'h1);
    endtask
    task automatic opc(input logic [1:0] op, input logic [11:0] c,
        input logic [63:0] a, b, r, input logic [31:0] s, input bit chk);
        logic [31:0] st, lo, hi, tk;
        wr(fpc_pkg::A_CTRL, {20'h0, c});
        ld(a, b);
        run(op, st, tk);
        cmp("cause", {32'h0, s}, {32'h0, st & 32'h01F60000});
        cmp("trap", {63'h0, s[17]}, {63'h0, fp_trap});
        if (chk)
        begin
            rd(fpc_pkg::A_RESL, lo);
            rd(fpc_pkg::A_RESH, hi);
            cmp("result", r, {hi, lo});
        end
    endtask
    task automatic fm(input logic [11:0] c, input logic [63:0] a, b, r,
        input logic [31:0] s, input bit chk);
        opc(fpc_pkg::OFMUL, c, a, b, r, s, chk);
    endtask
    task automatic lat(input logic [11:0] c, input logic [31:0] l);
        logic [31:0] st, tk;
        wr(fpc_pkg::A_CTRL, {20'h0, c});
        ld(64'h1, 64'h3FF000003F800000);
        run(fpc_pkg::OFMUL, st, tk);
        cmp("unimp", 64'h60000, {32'h0, st & 32'h00060000});
        cmp("latency", {32'h0, l}, {32'h0, rise_cycle - tk});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (cyc_now == 32'h4E20)
        begin
            bad_count++;
            give_verdict;
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(fpc_pkg::A_CTRL, q);
        cmp("ctrl", 64'h0, {32'h0, q});
        rd(fpc_pkg::A_STAT, q);
        cmp("stat", 64'h101, {32'h0, q});
        wr(8'h28, 32'hFFFFFFFF);
        rd(8'h28, q);
        cmp("unmapped", 64'h0, {32'h0, q});
        $display("test reset done");
        for (int i = 0; i < 11; i++)
        begin
            wr(fpc_pkg::A_CTRL, {20'h0, cc[i]});
            ld({ch[i], cl[i]}, {ch[i], cl[i]});
            rd(fpc_pkg::A_STAT, q);
            cmp("class", {50'h0, ck[i], 2'h0, ck[i]},
                {50'h0, q[13:0]});
        end
        $display("test classify done");
        fm(12'h000, 64'h3FF8000000000000, 64'h4000000000000000,
            64'h4008000000000000, 32'h0, 1);
        fm(12'h000, 64'h3FF0000000000001, 64'h3FF8000000000000,
            64'h3FF8000000000001, 32'h01000000, 1);
        fm(12'h001, 64'h3FF0000000000001, 64'h3FF8000000000000,
            64'h3FF8000000000001, 32'h01000000, 1);
        fm(12'h002, 64'h3FF0000000000001, 64'h3FF8000000000000,
            64'h3FF8000000000002, 32'h01000000, 1);
        fm(12'h003, 64'h3FF0000000000001, 64'h3FF8000000000000,
            64'h3FF8000000000001, 32'h01000000, 1);
        fm(12'h003, 64'hBFF0000000000001, 64'h3FF8000000000000,
            64'hBFF8000000000002, 32'h01000000, 1);
        fm(12'h002, 64'hBFF0000000000001, 64'h3FF8000000000000,
            64'hBFF8000000000001, 32'h01000000, 1);
        fm(12'h000, 64'h3FF0000000000001, 64'h3FFC000000000000,
            64'h3FFC000000000002, 32'h01000000, 1);
        $display("test rounding done");
        fm(12'h020, 64'h7FE0000000000000, 64'h4000000000000000,
            64'h7FF0000000000000, 32'h01420000, 1);
        fm(12'h000, 64'h7FF8000000000000, 64'h3FF0000000000000,
            64'h7FF7FFFFFFFFFFFF, 32'h00160000, 1);
        fm(12'h400, 64'h7FF8000000000000, 64'h3FF0000000000000,
            64'h7FF7FFFFFFFFFFFF, 32'h00100000, 1);
        fm(12'h408, 64'h7FF8000000000000, 64'h3FF0000000000000,
            64'h7FF7FFFFFFFFFFFF, 32'h00120000, 1);
        fm(12'h400, 64'h7FF7FFFFFFFFFFFF, 64'h3FF0000000000000,
            64'h7FF7FFFFFFFFFFFF, 32'h0, 1);
        fm(12'h404, 64'h0010000000000000, 64'h3FE0000000000000,
            64'h0, 32'h01800000, 1);
        fm(12'h400, 64'h0010000000000000, 64'h3FE0000000000000,
            64'h0, 32'h01860000, 0);
        fm(12'h200, 64'h3FF8000000000000, 64'h4000000000000000,
            64'h0, 32'h00060000, 0);
        fm(12'hA00, 64'h3FC00000, 64'h40000000, 64'h40400000,
            32'h0, 1);
        $display("test exceptions done");
        opc(fpc_pkg::OIMUL, 12'h000, 64'hFFFFFFFF, 64'h2,
            64'h00000001FFFFFFFE, 32'h0, 1);
        opc(fpc_pkg::OIDIV, 12'h000, 64'h64, 64'h7,
            64'h000000020000000E, 32'h0, 1);
        opc(fpc_pkg::OIDIV, 12'h000, 64'h64, 64'h0,
            64'h0, 32'h00200000, 1);
        opc(fpc_pkg::OFCLS, 12'h000, 64'h7FF8000000000000, 64'h0,
            64'h7FF8000000000000, 32'h0, 1);
        $display("test integer done");
        lat(12'h000, 32'h8);
        lat(12'h100, 32'h5);
        lat(12'h900, 32'h4);
        $display("test latency done");
        wr(fpc_pkg::A_FLAG, 32'h1F);
        fm(12'h000, 64'h3FF0000000000001, 64'h3FF8000000000000,
            64'h3FF8000000000001, 32'h01000000, 1);
        bus(1'b1, fpc_pkg::A_FLAG, 4'h0, 32'h1F, q);
        rd(fpc_pkg::A_FLAG, q);
        cmp("flags", 64'h10, {32'h0, q});
        wr(fpc_pkg::A_FLAG, 32'h10);
        rd(fpc_pkg::A_FLAG, q);
        cmp("flags", 64'h0, {32'h0, q});
        $display("test flags done");
        give_verdict;
    end
endmodule
